// ---- src/sfc_pkg.sv ----
// package for the serial flash command front end with password unlock
// assumes a 50 MHz core clock and an SPI mode 0 link clock from the host
package sfc_pkg;
  localparam int CORE_CLK_MHZ       = 50;
  // unlock attempt spacing, in microseconds
  localparam int UNLOCK_GAP_US      = 100;
  localparam int UNLOCK_GAP_TOL_US  = 20;
  localparam int UNLOCK_GAP_CYC     = UNLOCK_GAP_US * CORE_CLK_MHZ;
  localparam int PW_BITS            = 64;
  localparam int ADDR_BITS          = 32;
  // instruction codes of this front end; OP_PWDR is not acted on
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_READ4   = 8'h13;
  localparam logic [7:0] OP_DOR4    = 8'h3C;
  localparam logic [7:0] OP_QOR4    = 8'h6C;
  localparam logic [7:0] OP_DIOR4   = 8'hBC;
  localparam logic [7:0] OP_QIOR4   = 8'hEC;
  localparam logic [7:0] OP_PWDP    = 8'hE8;
  localparam logic [7:0] OP_PWDR    = 8'hE7;
  localparam logic [7:0] OP_PWUL    = 8'hE9;
  localparam logic [7:0] OP_MODE_WR = 8'h2F;
  localparam logic [7:0] OP_CLR_ST  = 8'h30;
  localparam logic [7:0] CONT_MODE  = 8'hA0;
  localparam int DUMMY_CYC          = 8;
  // protection mode lock bits, [2:1] of the config byte
  localparam logic [1:0] MODE_PASSWORD = 2'b01;
  localparam logic [1:0] MODE_ILLEGAL  = 2'b00;
  localparam logic [7:0] MODE_CFG_RST  = 8'hFF;
  localparam logic [63:0] PW_RST       = 64'hFFFF_FFFF_FFFF_FFFF;
  typedef enum logic [1:0] {W1, W2, W4} sfc_width_t;
endpackage

// ---- src/sfc_frontend.sv ----
// serial flash command front end with password unlock of the guard lock
// assumes sck_in from the host in SPI mode 0; cs_n_in framed per command
//
// Functional notes
// - unlock only on exact 64-bit password match
// - lock forced to 0 at reset in password mode
// - successful unlock sets lock, guard bits changeable
// - password program only clears bits
// - password mode ignores password program and read
// - mode lock bits never erased
// - mismatch: lock kept, program error, pending stays
// - after a mismatch, unlock attempts ignored for 100 us
// - valid password clears pending without delay
// - instruction is 8 bits on SI
// - address is 24 or 32 bits, bytewise
// - output commands: address on SI, data multi-lane
// - io commands: address and data multi-lane
// - lane width chosen from instruction only
// - msb first, whole bytes
// - address msb byte first, data address increments
// - continuation mode skips next instruction
// - reads other than READ and READ4 insert dummy cycles before data
// - array reads ignored while operation pending
// - command framed by chip select low
// - partial-byte frames rejected for some commands
// - lock 0 blocks guard bit change
// - mode bits 01 select password mode
`timescale 1ns/1ps
`default_nettype none
module sfc_frontend
  import sfc_pkg::*;
(
  input  wire logic        core_clk_in,    // core clock
  input  wire logic        srst_in,        // sync reset, high
  input  wire logic        sck_in,         // link clock from host
  input  wire logic        cs_n_in,        // chip select, low
  input  wire logic [3:0]  io_in,          // io0..io3 pin levels
  output logic      [3:0]  io_out,         // io drive values
  output logic      [3:0]  io_oe_out,      // io drive enables
  output logic      [31:0] rd_addr_out,    // array byte address
  output logic             rd_req_out,     // array byte request pulse
  input  wire logic [7:0]  rd_data_in,     // array byte data
  output logic             guard_lock_out, // protection_bits_lock
  output logic             pending_out,    // operation_pending_flag
  output logic             prog_err_out,   // program error flag
  output logic      [7:0]  mode_cfg_out    // protection_mode_config
);
  // ===========================================================
  // link domain: shifter
  // ===========================================================
  typedef struct packed {
    logic [7:0]  opcode;
    logic        have_op;
    logic        cont;
    logic [63:0] sh;
    logic [7:0]  bitcnt;
    logic [2:0]  phase;
    logic [3:0]  dcnt;
    logic [31:0] addr;
    logic        rd_tgl;
  } sfc_link_t;
  sfc_link_t lk, next_lk;

  localparam logic [2:0] PH_OP = 3'd0, PH_ADR = 3'd1, PH_MOD = 3'd2,
                         PH_DUM = 3'd3, PH_DAT = 3'd4, PH_IN = 3'd5;

  function automatic sfc_width_t addr_w(input logic [7:0] op);
    case (op)
      OP_DIOR4: addr_w = W2;
      OP_QIOR4: addr_w = W4;
      default:  addr_w = W1;
    endcase
  endfunction

  function automatic sfc_width_t data_w(input logic [7:0] op);
    case (op)
      OP_DOR4, OP_DIOR4: data_w = W2;
      OP_QOR4, OP_QIOR4: data_w = W4;
      default:           data_w = W1;
    endcase
  endfunction

  function automatic logic [2:0] lanes(input sfc_width_t w);
    case (w)
      W2:      lanes = 3'd2;
      W4:      lanes = 3'd4;
      default: lanes = 3'd1;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == OP_READ) || (op == OP_READ4) || (op == OP_DOR4) ||
              (op == OP_QOR4) || (op == OP_DIOR4) || (op == OP_QIOR4);
  endfunction

  function automatic logic [7:0] addr_bits(input logic [7:0] op);
    addr_bits = (op == OP_READ) ? 8'd24 : 8'd32;
  endfunction

  // status and read byte from core domain, sampled in link domain
  logic [7:0] stat_s1, stat_s2;
  logic [7:0] rdb_hold;
  logic [7:0] tx_byte;
  sfc_width_t dw_r;
  logic       tx_active;
  logic       fresh;

  always_comb begin
    logic [2:0]  n;
    logic [63:0] shn;
    sfc_link_t   cur;
    n   = 3'd1;
    shn = 64'h0;
    cur = lk;
    if (fresh) begin
      // new frame; continuation skips the instruction
      cur.have_op = lk.cont && is_read(lk.opcode);
      cur.phase   = (lk.cont && is_read(lk.opcode)) ? PH_ADR : PH_OP;
      cur.bitcnt  = 8'd0;
      cur.sh      = 64'h0;
      cur.cont    = 1'b0;
    end
    next_lk = cur;
    if (!cur.have_op && cur.phase == PH_OP) begin
      next_lk.sh     = {cur.sh[62:0], io_in[0]};
      next_lk.bitcnt = cur.bitcnt + 8'd1;
      if (cur.bitcnt == 8'd7) begin
        next_lk.opcode  = {cur.sh[6:0], io_in[0]};
        next_lk.have_op = 1'b1;
        next_lk.bitcnt  = 8'd0;
        next_lk.sh      = 64'h0;
        if (is_read({cur.sh[6:0], io_in[0]}))
          next_lk.phase = PH_ADR;
        else
          next_lk.phase = PH_IN;
      end
    end else begin
      case (cur.phase)
        PH_ADR: begin
          n   = lanes(addr_w(cur.opcode));
          shn = (n == 3'd4) ? {cur.sh[59:0], io_in} :
                (n == 3'd2) ? {cur.sh[61:0], io_in[1:0]} :
                              {cur.sh[62:0], io_in[0]};
          next_lk.sh     = shn;
          next_lk.bitcnt = cur.bitcnt + 8'(n);
          if (cur.bitcnt + 8'(n) == addr_bits(cur.opcode)) begin
            next_lk.addr   = shn[31:0];
            next_lk.bitcnt = 8'd0;
            next_lk.dcnt   = 4'd0;
            // first byte fetched now, hidden behind the dummies except for READ and READ4
            next_lk.rd_tgl = ~cur.rd_tgl;
            if (cur.opcode == OP_READ || cur.opcode == OP_READ4)
              next_lk.phase = PH_DAT;
            else
              next_lk.phase = (addr_w(cur.opcode) == W1) ? PH_DUM : PH_MOD;
          end
        end
        PH_MOD: begin
          n   = lanes(addr_w(cur.opcode));
          shn = (n == 3'd4) ? {cur.sh[59:0], io_in} :
                              {cur.sh[61:0], io_in[1:0]};
          next_lk.sh     = shn;
          next_lk.bitcnt = cur.bitcnt + 8'(n);
          if (cur.bitcnt + 8'(n) == 8'd8) begin
            next_lk.cont   = (shn[7:0] == CONT_MODE);
            next_lk.bitcnt = 8'd0;
            next_lk.phase  = PH_DUM;
          end
        end
        PH_DUM: begin
          next_lk.dcnt = cur.dcnt + 4'd1;
          if (cur.dcnt == 4'(DUMMY_CYC - 1)) begin
            next_lk.phase  = PH_DAT;
            next_lk.bitcnt = 8'd0;
          end
        end
        PH_DAT: begin
          n = lanes(dw_r);
          next_lk.bitcnt = cur.bitcnt + 8'(n);
          if (cur.bitcnt == 8'd0) begin
            // prefetch the following byte while this one shifts
            next_lk.addr   = cur.addr + 32'd1;
            next_lk.rd_tgl = ~cur.rd_tgl;
          end
          if (cur.bitcnt + 8'(n) == 8'd8)
            next_lk.bitcnt = 8'd0;
        end
        PH_IN: begin
          next_lk.sh     = {cur.sh[62:0], io_in[0]};
          next_lk.bitcnt = cur.bitcnt + 8'd1;
        end
        default: next_lk.phase = PH_OP;
      endcase
    end
  end

  // frame contents stay put after cs rises; link clock idle then
  always_ff @(posedge sck_in) begin
    lk <= next_lk;
  end

  // first link edge after cs low restarts the frame
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in)
      fresh <= 1'b1;
    else
      fresh <= 1'b0;
  end

  // output on falling edge, msb first
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      tx_active <= 1'b0;
      dw_r      <= W1;
      tx_byte   <= 8'h0;
    end else begin
      dw_r <= data_w(lk.opcode);
      if (lk.have_op && lk.opcode == OP_RDSR1) begin
        tx_active <= 1'b1;
        tx_byte   <= (lk.bitcnt == 8'd0 && !tx_active) ? stat_s2 :
                     {tx_byte[6:0], 1'b0};
      end else if (lk.phase == PH_DAT) begin
        tx_active <= 1'b1;
        case (dw_r)
          W4:      tx_byte <= (lk.bitcnt == 8'd0) ? rdb_hold :
                              {tx_byte[3:0], 4'h0};
          W2:      tx_byte <= (lk.bitcnt == 8'd0) ? rdb_hold :
                              {tx_byte[5:0], 2'h0};
          default: tx_byte <= (lk.bitcnt == 8'd0) ? rdb_hold :
                              {tx_byte[6:0], 1'b0};
        endcase
      end
    end
  end

  always_ff @(posedge sck_in) begin
    stat_s1 <= {6'h0, prog_err_out, pending_out};
    stat_s2 <= stat_s1;
  end

  always_comb begin
    io_out    = 4'h0;
    io_oe_out = 4'h0;
    if (tx_active && !cs_n_in) begin
      case (dw_r)
        W4: begin
          io_out    = tx_byte[7:4];
          io_oe_out = 4'hF;
        end
        W2: begin
          io_out    = {2'b00, tx_byte[7:6]};
          io_oe_out = 4'h3;
        end
        default: begin
          io_out    = {2'b00, tx_byte[7], 1'b0};
          io_oe_out = 4'h2;
        end
      endcase
    end
  end

  // ===========================================================
  // core domain: command execution
  // ===========================================================
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  rd_sync;
    logic [63:0] pw;
    logic [7:0]  mode_cfg;
    logic        lock;
    logic        pend;
    logic        perr;
    logic [31:0] gap;
    logic        busy;
    logic [31:0] raddr;
    logic        rreq;
    logic [7:0]  rbyte;
  } sfc_core_t;
  sfc_core_t next_cr;
  // nonvolatile password and mode start erased at power-up
  sfc_core_t cr = '{pw: PW_RST, mode_cfg: MODE_CFG_RST, default: '0};

  assign rdb_hold = cr.rbyte;

  always_comb begin
    logic done_ev;
    logic rd_ev;
    logic pw_mode;
    // frame end: cs rise seen after two flops
    done_ev = cr.cs_sync[1] && !cr.cs_sync[2] && lk.have_op &&
              (lk.phase == PH_IN);
    rd_ev   = cr.rd_sync[2] ^ cr.rd_sync[1];
    pw_mode = (cr.mode_cfg[2:1] == MODE_PASSWORD);
    next_cr = cr;
    next_cr.cs_sync   = {cr.cs_sync[1:0], cs_n_in};
    next_cr.rd_sync   = {cr.rd_sync[1:0], lk.rd_tgl};
    next_cr.rreq      = 1'b0;
    if (rd_ev && !cr.pend) begin
      next_cr.raddr = lk.addr;
      next_cr.rreq  = 1'b1;
    end
    if (cr.rreq)
      next_cr.rbyte = rd_data_in;
    if (cr.busy) begin
      // pending held through the spacing window
      next_cr.gap = cr.gap - 32'd1;
      if (cr.gap == 32'd1) begin
        next_cr.busy = 1'b0;
        next_cr.pend = 1'b1;
      end
    end
    if (done_ev && !cr.busy) begin
      case (lk.opcode)
        OP_PWUL: begin
          if (pw_mode && lk.bitcnt == 8'(PW_BITS)) begin
            if (lk.sh == cr.pw) begin
              next_cr.lock = 1'b1;
              next_cr.pend = 1'b0;
            end else begin
              next_cr.perr = 1'b1;
              next_cr.pend = 1'b1;
              next_cr.busy = 1'b1;
              next_cr.gap  = 32'(UNLOCK_GAP_CYC);
            end
          end
        end
        OP_PWDP: begin
          // ignored in password mode; only clears bits
          if (!pw_mode && lk.bitcnt == 8'(PW_BITS))
            next_cr.pw = cr.pw & lk.sh;
        end
        OP_MODE_WR: begin
          // mode bits only cleared, and only while bits [2:1] are still 11
          if (cr.mode_cfg[2:1] == 2'b11 && lk.bitcnt == 8'd8) begin
            if (lk.sh[2:1] == MODE_ILLEGAL)
              next_cr.perr = 1'b1;
            else
              next_cr.mode_cfg = cr.mode_cfg & lk.sh[7:0];
          end
        end
        OP_CLR_ST: begin
          if (!cr.busy) begin
            next_cr.perr = 1'b0;
            next_cr.pend = 1'b0;
          end
        end
        default: next_cr.pend = cr.pend;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cr.cs_sync   <= 3'b111;   // idle high: no false frame end
      cr.rd_sync   <= 3'b000;
      cr.lock      <= 1'b0;     // locked out of reset
      cr.pend      <= 1'b0;
      cr.perr      <= 1'b0;
      cr.gap       <= 32'd0;
      cr.busy      <= 1'b0;
      cr.raddr     <= 32'h0;
      cr.rreq      <= 1'b0;
      cr.rbyte     <= 8'h0;
      cr.pw        <= cr.pw;
      cr.mode_cfg  <= cr.mode_cfg;
    end else begin
      cr <= next_cr;
    end
  end

  assign rd_addr_out    = cr.raddr;
  assign rd_req_out     = cr.rreq;
  assign guard_lock_out = cr.lock;
  assign pending_out    = cr.pend;
  assign prog_err_out   = cr.perr;
  assign mode_cfg_out   = cr.mode_cfg;
endmodule
`default_nettype wire

// ---- tb/sfc_frontend_sva.sv ----
// checker for flag, drive and array request behaviour
// assumes binding to sfc_frontend; one core clock domain
`timescale 1ns/1ps
`default_nettype none
module sfc_frontend_chk (
  input wire logic        core_clk_in,    // core clock
  input wire logic        srst_in,        // sync reset
  input wire logic        cs_n_in,        // chip select
  input wire logic [3:0]  io_oe_out,      // io enables
  input wire logic [31:0] rd_addr_out,    // array address
  input wire logic        rd_req_out,     // array request
  input wire logic        guard_lock_out, // guard lock
  input wire logic        pending_out,    // pending flag
  input wire logic        prog_err_out,   // program error
  input wire logic [7:0]  mode_cfg_out    // mode config
);
  logic [31:0] last_a;
  logic        seen;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // previous array address within one frame
  always_ff @(posedge core_clk_in) begin
    if (cs_n_in) begin
      seen <= 1'b0;
    end else if (rd_req_out) begin
      seen   <= 1'b1;
      last_a <= rd_addr_out;
    end
  end
  // ==========================================
  // assertions
  reset_clear_a: assert property (disable iff (1'b0)
    srst_in |=> !guard_lock_out && !pending_out && !prog_err_out)
    else $error("flags not cleared by reset");
  unlock_after_a: assert property (
    $rose(guard_lock_out) |-> cs_n_in)
    else $error("lock set inside a frame");
  miss_keep_a: assert property (
    $rose(prog_err_out) |-> $stable(guard_lock_out) && pending_out)
    else $error("mismatch changed lock or dropped pending");
  err_pend_a: assert property (prog_err_out |-> pending_out)
    else $error("error without pending");
  lock_pend_a: assert property (
    $rose(guard_lock_out) |-> !pending_out)
    else $error("pending left set on unlock");
  mode_frozen_a: assert property (
    mode_cfg_out[2:1] == 2'b01 |=> $stable(mode_cfg_out))
    else $error("mode config changed in password mode");
  idle_release_a: assert property (
    cs_n_in [*4] |-> io_oe_out == 4'h0)
    else $error("io driven while deselected");
  addr_step_a: assert property (
    rd_req_out && seen |-> rd_addr_out == last_a + 32'h0000_0001)
    else $error("array address did not step by one");
  pend_read_a: assert property (pending_out |-> !rd_req_out)
    else $error("array read while pending");
endmodule
bind sfc_frontend sfc_frontend_chk u_chk (
  .core_clk_in(core_clk_in), .srst_in(srst_in), .cs_n_in(cs_n_in),
  .io_oe_out(io_oe_out), .rd_addr_out(rd_addr_out),
  .rd_req_out(rd_req_out), .guard_lock_out(guard_lock_out),
  .pending_out(pending_out), .prog_err_out(prog_err_out),
  .mode_cfg_out(mode_cfg_out));
`default_nettype wire

// ---- tb/sfc_host.sv ----
// host controller model: frames commands on the link
// assumes mode 0; 80 ns link clock, stopped between frames
`timescale 1ns/1ps
`default_nettype none
module sfc_host
  import sfc_pkg::*;
(
  output logic            sck_out,   // link clock
  output logic            cs_n_out,  // chip select
  output logic      [3:0] pin_out,   // resolved pin levels
  input  wire logic [3:0] dev_io_in, // device drive values
  input  wire logic [3:0] dev_oe_in  // device drive enables
);
  logic [3:0] h_io, h_oe, idle;
  logic [7:0] rx;
  event       rx_ev;
  // released lines show a toggling pattern
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_out[i] = dev_oe_in[i] ? dev_io_in[i] :
                   h_oe[i] ? h_io[i] : idle[i];
    end
  end
  initial begin
    sck_out = 1'b0; cs_n_out = 1'b1; h_oe = 4'h0; h_io = 4'h0;
    idle = 4'h5;
    forever #40 idle = ~idle;
  end
  task automatic pulse();
    #40 sck_out = 1'b1;
    #40 sck_out = 1'b0;
  endtask
  task automatic bit_out(input logic b);
    h_io[0] = b;
    h_oe = 4'h1;
    pulse();
  endtask
  task automatic frame(input logic [7:0] op, input logic [63:0] pay,
                       input int nb, input int rd);
    cs_n_out = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) bit_out(op[i]);
    for (int i = nb - 1; i >= 0; i--) bit_out(pay[i]);
    h_oe = 4'h0;
    if (rd > 0) repeat (DUMMY_CYC) pulse();
    for (int b = 0; b < rd; b++) begin
      for (int k = 0; k < 2; k++) begin
        #40 rx = {rx[3:0], pin_out};
        sck_out = 1'b1;
        #40 sck_out = 1'b0;
      end
      -> rx_ev;
    end
    #40 cs_n_out = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_sfc_frontend.sv ----
// self-checking bench for the command front end
// assumes sfc_host drives the link; array bytes modelled here
`timescale 1ns/1ps
`default_nettype none
module tb_sfc_frontend;
  import sfc_pkg::*;
  logic        core_clk_in, srst_in, sck, cs_n, quiet;
  logic [3:0]  pins, io_out, io_oe_out;
  logic [31:0] rd_addr_out, st, a;
  logic        rd_req_out, guard_lock_out, pending_out, prog_err_out;
  logic [7:0]  rd_data_in, mode_cfg_out;
  logic [63:0] pw;
  logic [7:0]  q[$];
  int          mismatches, check_count, req_cnt, n;
  sfc_frontend DUT (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .sck_in(sck), .cs_n_in(cs_n), .io_in(pins), .io_out(io_out),
    .io_oe_out(io_oe_out), .rd_addr_out(rd_addr_out),
    .rd_req_out(rd_req_out), .rd_data_in(rd_data_in),
    .guard_lock_out(guard_lock_out), .pending_out(pending_out),
    .prog_err_out(prog_err_out), .mode_cfg_out(mode_cfg_out));
  sfc_host host (.sck_out(sck), .cs_n_out(cs_n), .pin_out(pins),
    .dev_io_in(io_out), .dev_oe_in(io_oe_out));
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask
  // array byte follows the requested address
  always @(posedge core_clk_in) begin
    #1 rd_data_in = rd_addr_out[7:0] ^ 8'h5A;
    if (rd_req_out === 1'b1) req_cnt++;
  end
  // result side: each returned byte against the oldest note
  always @(host.rx_ev) begin
    if (!quiet) begin
      chk(q.size() != 0, 1'b1);
      if (q.size() != 0) chk(host.rx, q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge core_clk_in);
    mismatches++;
    $display("timeout");
    wrap_up();
  end
  initial begin
    srst_in = 1'b1; rd_data_in = 8'h00; st = 32'h0000_0007;
    mismatches = 0; check_count = 0; req_cnt = 0; quiet = 1'b0;
    tick(12);
    srst_in = 1'b0;
    tick(4);
    chk({guard_lock_out, pending_out, prog_err_out}, 3'b000);
    $display("test reset done");
    // password first, then the mode is chosen
    pw = {xs(), xs()};
    host.frame(OP_PWDP, pw, 64, 0);
    host.frame(OP_PWDP, 64'hFFFF_FFFF_FFFF_FFFF, 64, 0);
    host.frame(OP_MODE_WR, 64'h0000_0000_0000_00FB, 8, 0);
    tick(10);
    chk(mode_cfg_out, 8'hFB);
    host.frame(OP_PWDP, 64'h0000_0000_0000_0000, 64, 0);
    host.frame(OP_MODE_WR, 64'h0000_0000_0000_00FF, 8, 0);
    tick(10);
    chk(mode_cfg_out, 8'hFB);
    $display("test mode done");
    a = xs();
    q.push_back(a[7:0] ^ 8'h5A);
    q.push_back(8'(a + 32'h0000_0001) ^ 8'h5A);
    host.frame(OP_QOR4, {32'h0000_0000, a}, 32, 2);
    tick(10);
    chk(q.size(), 0);
    $display("test read done");
    host.frame(OP_PWUL, pw, 63, 0);
    tick(10);
    chk(guard_lock_out, 1'b0);
    host.frame(OP_PWUL, pw ^ 64'h0000_0000_0000_0001, 64, 0);
    tick(10);
    chk({guard_lock_out, pending_out, prog_err_out}, 3'b011);
    n = req_cnt;
    quiet = 1'b1;
    host.frame(OP_QOR4, {32'h0000_0000, a}, 32, 1);
    tick(10);
    quiet = 1'b0;
    chk(req_cnt, n);
    tick(3000);
    host.frame(OP_PWUL, pw, 64, 0);
    tick(10);
    chk({guard_lock_out, pending_out}, 2'b01);
    tick(3500);
    host.frame(OP_CLR_ST, 64'h0000_0000_0000_0000, 0, 0);
    tick(10);
    chk({pending_out, prog_err_out}, 2'b00);
    host.frame(OP_PWUL, pw, 64, 0);
    tick(10);
    chk({guard_lock_out, pending_out, prog_err_out}, 3'b100);
    $display("test unlock done");
    srst_in = 1'b1;
    tick(12);
    srst_in = 1'b0;
    tick(4);
    chk(guard_lock_out, 1'b0);
    chk(mode_cfg_out, 8'hFB);
    $display("test second reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
